// File: logic/ppc_port_pad_config_regs.sv
`timescale 1ns/1ps
// Purpose: pad control register bank for the general-purpose ports
// Assumes: same-clock special-function bus; page chosen by the processor
// Notes: read data is registered one cycle after the read strobe
module ppc_port_pad_config_regs (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire ppc_pkg::ppc_bus_s bus,
	output logic [7:0]            rdata,
	output logic                  rhit,
	input  wire logic             reset_pin_disable_cfg,
	input  wire logic             pin20_pad_in,
	input  wire logic             timer0_overflow,
	input  wire logic             timer1_overflow,
	output ppc_pkg::ppc_mode_e    port3_mode,
	output ppc_pkg::ppc_pad_s     pad_cfg,
	output logic                  pin20_pull_up,
	output logic                  pin20_in,
	output logic                  timer0_toggle_pin,
	output logic                  timer1_toggle_pin,
	output logic                  timer0_toggle_out_enable,
	output logic                  timer1_toggle_out_enable
);
	logic [7:0] port3_mode_select_low;
	logic [7:0] port3_mode_select_high;
	logic [7:0] port3_input_type;
	logic [7:0] port0_input_type;
	logic [7:0] port1_input_type;
	logic [7:0] port0_slew_rate;
	logic [7:0] port1_slew_rate;
	logic [7:0] pin20_setting_timer_out;
	logic       cfg_meta;
	logic       cfg_sync;
	logic       pin_meta;
	logic       pin_sync;
	logic       pg0;
	logic       pg1;
	logic [7:0] next_rdata;
	logic       next_rhit;

	assign pg0 = bus.page == ppc_pkg::PAGE_BASE;
	// port 3 input type shares offset AC with page 0, so page decides
	assign pg1 = bus.page == ppc_pkg::PAGE_EXT;

	// configuration strap and pad arrive from outside the clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// assume reset pin until the strap is seen: pull-up never dips
			cfg_meta <= 1'b1;
			cfg_sync <= 1'b1;
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			cfg_meta <= reset_pin_disable_cfg;
			cfg_sync <= cfg_meta;
			pin_meta <= pin20_pad_in;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port3_mode_select_low  <= ppc_pkg::RST_P3_MODE_LOW;
			port3_mode_select_high <= ppc_pkg::RST_ZERO;
		end else if (bus.write && pg0) begin
			if (bus.addr == ppc_pkg::ADDR_P3_MODE_LOW)
				port3_mode_select_low <= bus.wdata & ppc_pkg::MASK_BIT0;
			if (bus.addr == ppc_pkg::ADDR_P3_MODE_HIGH)
				port3_mode_select_high <= bus.wdata & ppc_pkg::MASK_BIT0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port3_input_type <= ppc_pkg::RST_ZERO;
			port0_input_type <= ppc_pkg::RST_ZERO;
			port1_input_type <= ppc_pkg::RST_ZERO;
			port0_slew_rate  <= ppc_pkg::RST_ZERO;
			port1_slew_rate  <= ppc_pkg::RST_ZERO;
		end else if (bus.write && pg1) begin
			case (bus.addr)
				ppc_pkg::ADDR_P3_IN_TYPE:
					port3_input_type <= bus.wdata & ppc_pkg::MASK_BIT0;
				ppc_pkg::ADDR_P0_IN_TYPE: port0_input_type <= bus.wdata;
				ppc_pkg::ADDR_P1_IN_TYPE: port1_input_type <= bus.wdata;
				ppc_pkg::ADDR_P0_SLEW:    port0_slew_rate  <= bus.wdata;
				ppc_pkg::ADDR_P1_SLEW:    port1_slew_rate  <= bus.wdata;
				default: ;
			endcase
		end
	end

	// the pin 2.0 setting register is visible on both pages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin20_setting_timer_out <= ppc_pkg::RST_ZERO;
		end else if (bus.write && bus.addr == ppc_pkg::ADDR_PIN20_SET) begin
			pin20_setting_timer_out <= bus.wdata & ppc_pkg::MASK_PIN20_SET;
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		next_rhit  = 1'b0;
		if (bus.addr == ppc_pkg::ADDR_PIN20_SET) begin
			next_rdata = pin20_setting_timer_out;
			next_rhit  = 1'b1;
		end else if (pg0) begin
			case (bus.addr)
				ppc_pkg::ADDR_P3_MODE_LOW: begin
					next_rdata = port3_mode_select_low;
					next_rhit  = 1'b1;
				end
				ppc_pkg::ADDR_P3_MODE_HIGH: begin
					next_rdata = port3_mode_select_high;
					next_rhit  = 1'b1;
				end
				default: ;
			endcase
		end else begin
			next_rhit = 1'b1;
			case (bus.addr)
				ppc_pkg::ADDR_P3_IN_TYPE: next_rdata = port3_input_type;
				ppc_pkg::ADDR_P0_IN_TYPE: next_rdata = port0_input_type;
				ppc_pkg::ADDR_P1_IN_TYPE: next_rdata = port1_input_type;
				ppc_pkg::ADDR_P0_SLEW:    next_rdata = port0_slew_rate;
				ppc_pkg::ADDR_P1_SLEW:    next_rdata = port1_slew_rate;
				default:                  next_rhit  = 1'b0;
			endcase
		end
	end

	// unmapped addresses read zero with rhit low so other banks may answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rhit  <= 1'b0;
		end else if (bus.read) begin
			rdata <= next_rdata;
			rhit  <= next_rhit;
		end else begin
			rdata <= 8'h00;
			rhit  <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port3_mode <= ppc_pkg::PPC_INPUT;
			pad_cfg    <= '0;
		end else begin
			port3_mode <= ppc_pkg::ppc_mode_e'({port3_mode_select_low[0],
				port3_mode_select_high[0]});
			pad_cfg.p0_in_type  <= port0_input_type;
			pad_cfg.p1_in_type  <= port1_input_type;
			pad_cfg.p20_in_type <=
				pin20_setting_timer_out[ppc_pkg::BIT_P20_IN_TYPE];
			pad_cfg.p3_in_type  <= port3_input_type[0];
			pad_cfg.p0_slew     <= port0_slew_rate;
			pad_cfg.p1_slew     <= port1_slew_rate;
		end
	end

	// strap value 1 means the pin is reset: pull-up forced, data reads 0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin20_pull_up            <= 1'b1;
			pin20_in                 <= 1'b0;
			timer0_toggle_out_enable <= 1'b0;
			timer1_toggle_out_enable <= 1'b0;
		end else begin
			pin20_pull_up <= cfg_sync ? 1'b1
				: pin20_setting_timer_out[ppc_pkg::BIT_PULL_UP];
			pin20_in <= cfg_sync ? 1'b0 : pin_sync;
			timer0_toggle_out_enable <=
				pin20_setting_timer_out[ppc_pkg::BIT_T0_OUT_EN];
			timer1_toggle_out_enable <=
				pin20_setting_timer_out[ppc_pkg::BIT_T1_OUT_EN];
		end
	end

	ppc_toggle_out u_t0 (
		.clk      (clk),
		.rst_n    (rst_n),
		.enable   (pin20_setting_timer_out[ppc_pkg::BIT_T0_OUT_EN]),
		.overflow (timer0_overflow),
		.pin_out  (timer0_toggle_pin)
	);

	ppc_toggle_out u_t1 (
		.clk      (clk),
		.rst_n    (rst_n),
		.enable   (pin20_setting_timer_out[ppc_pkg::BIT_T1_OUT_EN]),
		.overflow (timer1_overflow),
		.pin_out  (timer1_toggle_pin)
	);
endmodule // ppc_port_pad_config_regs

// File: logic/ppc_pkg.sv
// Purpose: constants and carriers for the port pad configuration bank
// Assumes: paged special-function space, 8-bit data, page select 0/1
// Notes: How it works list follows
// How it works
// - pull-up bit acts only when pin not reset
// - port 3 mode decoded from low/high bits
// - port 3 mode resets to input-only
// - port 3 mode registers at AC/AD page 0
// - per-pin input type bit, reset zero
// - pin 2.0 input type bit 0 at B5
// - per-pin slew bit, normal after reset
// - timer pin toggles per overflow, starts high
// - pin 2.0 input only, reads 0 otherwise
package ppc_pkg;
	localparam logic [7:0] ADDR_P3_MODE_LOW  = 8'hAC;
	localparam logic [7:0] ADDR_P3_MODE_HIGH = 8'hAD;
	localparam logic [7:0] ADDR_P3_IN_TYPE   = 8'hAC;
	localparam logic [7:0] ADDR_P0_IN_TYPE   = 8'hB1;
	localparam logic [7:0] ADDR_P0_SLEW      = 8'hB2;
	localparam logic [7:0] ADDR_P1_IN_TYPE   = 8'hB3;
	localparam logic [7:0] ADDR_P1_SLEW      = 8'hB4;
	localparam logic [7:0] ADDR_PIN20_SET    = 8'hB5;
	localparam logic       PAGE_BASE         = 1'b0;
	localparam logic       PAGE_EXT          = 1'b1;
	localparam logic [7:0] RST_P3_MODE_LOW   = 8'h01;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [7:0] MASK_BIT0         = 8'h01;
	localparam logic [7:0] MASK_PIN20_SET    = 8'h8D;
	localparam int         BIT_PULL_UP       = 7;
	localparam int         BIT_T1_OUT_EN     = 3;
	localparam int         BIT_T0_OUT_EN     = 2;
	localparam int         BIT_P20_IN_TYPE   = 0;

	typedef enum logic [1:0] {
		PPC_QUASI     = 2'h0,
		PPC_PUSH_PULL = 2'h1,
		PPC_INPUT     = 2'h2,
		PPC_OPEN      = 2'h3
	} ppc_mode_e;

	typedef struct packed {
		logic       write;
		logic       read;
		logic       page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ppc_bus_s;

	typedef struct packed {
		logic [7:0] p0_in_type;
		logic [7:0] p1_in_type;
		logic       p20_in_type;
		logic       p3_in_type;
		logic [7:0] p0_slew;
		logic [7:0] p1_slew;
	} ppc_pad_s;
endpackage

// File: logic/ppc_toggle_out.sv
`timescale 1ns/1ps
// Purpose: one timer toggle output
// Assumes: overflow is a one-cycle pulse on clk
// Notes: output holds high while disabled
module ppc_toggle_out (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic overflow,
	output logic      pin_out
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 1'b1;
		end else if (!enable) begin
			// re-arm high so the first overflow after enabling drives low
			pin_out <= 1'b1;
		end else if (overflow) begin
			pin_out <= ~pin_out;
		end
	end
endmodule // ppc_toggle_out

// File: verif/ppc_port_pad_config_regs_monitor.sv
// Purpose: port-level checks for the pad config bank
// Assumes: one clock, registered outputs, strap synced in two flops
// Notes: strap checks wait four edges to cover the sync delay
`timescale 1ns/1ps
module ppc_monitor (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire ppc_pkg::ppc_bus_s  bus,
	input wire logic [7:0]         rdata,
	input wire logic               rhit,
	input wire logic               reset_pin_disable_cfg,
	input wire logic               timer0_overflow,
	input wire logic               timer1_overflow,
	input wire ppc_pkg::ppc_mode_e port3_mode,
	input wire ppc_pkg::ppc_pad_s  pad_cfg,
	input wire logic               pin20_pull_up,
	input wire logic               pin20_in,
	input wire logic               timer0_toggle_pin,
	input wire logic               timer1_toggle_pin,
	input wire logic               timer0_toggle_out_enable,
	input wire logic               timer1_toggle_out_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_idle_read_zero: assert property (
		!bus.read |=> rdata == 8'h00 && !rhit)
		else $error("read data without a read");
	a_mode_bit_only: assert property (
		bus.read && bus.addr == 8'hAC |=> rdata[7:1] == 7'h00)
		else $error("upper bits set at AC");
	a_mode_high_hit: assert property (
		bus.read && !bus.page && bus.addr == 8'hAD |=> rhit)
		else $error("AD page 0 not mapped");
	a_pullup_strap: assert property (
		reset_pin_disable_cfg[*4] |-> pin20_pull_up)
		else $error("pull-up off while pin is reset");
	a_pin20_low: assert property (
		reset_pin_disable_cfg[*4] |-> !pin20_in)
		else $error("pin 2.0 not low while reset pin");
	a_toggle_idle: assert property (
		(!timer0_toggle_out_enable)[*2] |-> timer0_toggle_pin)
		else $error("timer0 pin low while disabled");
	a_t1_idle: assert property (
		(!timer1_toggle_out_enable)[*2] |-> timer1_toggle_pin)
		else $error("timer1 pin low while disabled");
	a_t0_flip: assert property (
		timer0_overflow && timer0_toggle_out_enable
		##1 timer0_toggle_out_enable
		|-> timer0_toggle_pin != $past(timer0_toggle_pin))
		else $error("timer0 pin did not toggle");
	a_t1_flip: assert property (
		timer1_overflow && timer1_toggle_out_enable
		##1 timer1_toggle_out_enable
		|-> timer1_toggle_pin != $past(timer1_toggle_pin))
		else $error("timer1 pin did not toggle");
	a_cfg_holds: assert property (
		(!bus.write)[*2] |=> $stable(port3_mode) && $stable(pad_cfg))
		else $error("config moved without a write");
	c_toggle: cover property (timer0_overflow && timer0_toggle_out_enable);
	c_set_write: cover property (bus.write && bus.addr == 8'hB5);
	c_hit: cover property (rhit);
endmodule // ppc_monitor

// File: verif/ppc_port_pad_config_regs_tb_top.sv
// Purpose: register-level test of the pad config bank
// Assumes: strobes last one cycle, read data comes the next cycle
// Notes: B5 is written on page 0 to cover its either-page decode
`timescale 1ns/1ps
module ppc_port_pad_config_regs_tb_top;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	ppc_pkg::ppc_bus_s  b = '0;
	logic               cfg = 1'b0;
	logic               pad = 1'b0;
	logic [1:0]         ov = 2'b00;
	logic [7:0]         rdata;
	logic               rhit;
	ppc_pkg::ppc_mode_e mode;
	ppc_pkg::ppc_pad_s  pc;
	logic               pu;
	logic               p20;
	logic [1:0]         tp;
	logic [1:0]         te;
	int                 fail_count = 0;
	int                 cmp_count = 0;
	localparam logic [7:0] t_pg = 8'b0111_1100;
	localparam logic [0:7][7:0] t_ad = {8'hAC, 8'hAD, 8'hAC, 8'hB1,
		8'hB2, 8'hB3, 8'hB4, 8'hB5};
	localparam logic [0:7][7:0] t_wr = {8'hFF, 8'hFF, 8'hFF, 8'hB1,
		8'hB2, 8'hB3, 8'hB4, 8'hFF};
	localparam logic [0:7][7:0] t_ex = {8'h01, 8'h01, 8'h01, 8'hB1,
		8'hB2, 8'hB3, 8'hB4, 8'h8D};
	always #12.5 clk = ~clk;
	ppc_port_pad_config_regs dut (.clk(clk), .rst_n(rst_n), .bus(b),
		.rdata(rdata), .rhit(rhit), .reset_pin_disable_cfg(cfg),
		.pin20_pad_in(pad), .timer0_overflow(ov[0]),
		.timer1_overflow(ov[1]), .port3_mode(mode), .pad_cfg(pc),
		.pin20_pull_up(pu), .pin20_in(p20), .timer0_toggle_pin(tp[0]),
		.timer1_toggle_pin(tp[1]), .timer0_toggle_out_enable(te[0]),
		.timer1_toggle_out_enable(te[1]));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		b <= '{1'b1, 1'b0, pg, a, d};
		@(posedge clk);
		b.write <= 1'b0;
	endtask
	task automatic rd(input logic pg, input logic [7:0] a, input logic [7:0] e,
		input logic h);
		@(posedge clk);
		b <= '{1'b0, 1'b1, pg, a, 8'h00};
		@(posedge clk);
		b.read <= 1'b0;
		#1;
		chk(rdata, e);
		chk(rhit, h);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic pulse;
		@(posedge clk);
		ov <= 2'b11;
		@(posedge clk);
		ov <= 2'b00;
		#1;
	endtask
	task automatic report_and_stop;
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(mode, ppc_pkg::PPC_INPUT);
		chk(pc, 34'h0);
		chk({tp, te, pu}, 5'h18);
		for (int i = 0; i < 8; i++)
			rd(t_pg[i], t_ad[i], (i == 0) ? 8'h01 : 8'h00, 1'b1);
		for (int i = 0; i < 8; i++)
			wr(t_pg[i], t_ad[i], t_wr[i]);
		for (int i = 0; i < 8; i++)
			rd(t_pg[i], t_ad[i], t_ex[i], 1'b1);
		chk(pc, {8'hB1, 8'hB3, 2'b11, 8'hB2, 8'hB4});
		chk(mode, ppc_pkg::PPC_OPEN);
		chk({tp, te, pu}, 5'h1F);
		pulse;
		chk(tp, 2'b00);
		pulse;
		chk(tp, 2'b11);
		wr(1'b0, 8'hB2, 8'h00);
		rd(1'b1, 8'hB2, 8'hB2, 1'b1);
		rd(1'b0, 8'hB1, 8'h00, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(1'b0, 8'hAC, {7'h00, m[1]});
			wr(1'b0, 8'hAD, {7'h00, m[0]});
			settle;
			chk(mode, m[1:0]);
		end
		// page 1 shares AC/AD: these writes must leave the mode alone
		wr(1'b1, 8'hAC, 8'h00);
		wr(1'b1, 8'hAD, 8'h00);
		settle;
		chk(mode, ppc_pkg::PPC_OPEN);
		rd(1'b0, 8'hAC, 8'h01, 1'b1);
		rd(1'b1, 8'hAC, 8'h00, 1'b1);
		wr(1'b0, 8'hB5, 8'h00);
		pad <= 1'b1;
		settle;
		pulse;
		chk({tp, te, pu, p20}, 6'h31);
		@(posedge clk);
		cfg <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({pu, p20}, 2'b10);
		report_and_stop;
	end
	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule // ppc_port_pad_config_regs_tb_top
bind ppc_port_pad_config_regs ppc_monitor u_mon (.clk, .rst_n, .bus, .rdata,
	.rhit, .reset_pin_disable_cfg, .timer0_overflow, .timer1_overflow,
	.port3_mode, .pad_cfg, .pin20_pull_up, .pin20_in, .timer0_toggle_pin,
	.timer1_toggle_pin, .timer0_toggle_out_enable, .timer1_toggle_out_enable);
